// *** hdl/cie_char_exec.sv ***
// Fixed-length character instruction decode and execute unit
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cie_char_exec (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [15:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   input wire logic [31:0] mem_rdata_in,
   input wire logic mem_ack_in,
   output logic busy_out,
   output logic done_out,
   output logic [1:0] skip_count_out
);
   import cie_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      cie_state_e st;
      cie_instr_s ir;
      logic [NUM_REGS-1:0][CHAR_W-1:0] r;
      logic [31:0] word;
      logic [1:0] pos;
      logic ovf;
      logic ill;
      logic [1:0] skip;
      logic [CYC_W-1:0] cyc;
      logic [PACE_W-1:0] pace;
      logic wb_ack;
      logic [31:0] wb_dat;
      logic mreq;
      logic mwe;
      logic [15:0] maddr;
      logic [31:0] mwdata;
      logic done;
   } cie_regs_s;

   cie_regs_s s_reg;
   cie_regs_s s_next;
   logic [1:0] rst_sync_reg;
   logic rst_n;

   // Reset released through two flops
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   function automatic logic [CHAR_W-1:0] char_at(input logic [31:0] w, input logic [1:0] p);
      char_at = w[(CPW - 1 - int'(p)) * CHAR_W +: CHAR_W];
   endfunction

   function automatic logic [31:0] put_char(input logic [31:0] w, input logic [1:0] p,
                                            input logic [CHAR_W-1:0] c);
      logic [31:0] t;
      t = w;
      t[(CPW - 1 - int'(p)) * CHAR_W +: CHAR_W] = c;
      put_char = t;
   endfunction

   // ****************************************
   // Decode helpers
   // ****************************************
   logic [PAIR_W-1:0] idx;
   logic [17:0] ea;
   logic [17:0] imm;
   logic is_grp;
   logic imm_ok;
   logic needs_rd;
   logic legal;
   logic [CHAR_W-1:0] opnd;
   logic [CHAR_W-1:0] rsel;
   logic [CHAR_W:0] sum9;
   logic [CHAR_W:0] dif9;
   logic [PACE_W-1:0] pace_end;

   always_comb begin
      if (s_reg.ir.modify_sel == X_PAIR_TWO || s_reg.ir.modify_sel == X_PAIR_THREE) begin
         idx = {s_reg.r[s_reg.ir.modify_sel - 3'h2], s_reg.r[s_reg.ir.modify_sel]};
      end else if (s_reg.ir.modify_sel >= REG_HIGH_BASE) begin
         idx = {{(PAIR_W-CHAR_W){1'b0}}, s_reg.r[s_reg.ir.modify_sel]};
      end else begin
         idx = '0;
      end
      imm = {s_reg.ir.memory_loc, s_reg.ir.byte_pos};
      ea = imm + {2'h0, idx};
      is_grp = (s_reg.ir.op == OP_GROUP);
      imm_ok = (s_reg.ir.op == OP_LOAD_CHAR) || (s_reg.ir.op == OP_LOAD_CHAR_MASKED) ||
               (s_reg.ir.op == OP_ADD_CHAR) || (s_reg.ir.op == OP_SUB_CHAR) ||
               (s_reg.ir.op == OP_COMPARE_CHAR_MEM) ||
               (is_grp && (s_reg.ir.data_slot_sel == GRP_LOAD_INDEX_TWO ||
                           s_reg.ir.data_slot_sel == GRP_LOAD_INDEX_THREE));
      needs_rd = !(is_grp && (s_reg.ir.data_slot_sel == GRP_STORE_LOW ||
                              s_reg.ir.data_slot_sel == GRP_STORE_HIGH));
      legal = imm_ok || is_grp || (s_reg.ir.op == OP_STORE_CHAR) ||
              (s_reg.ir.op == OP_STORE_CHAR_MASKED);
      opnd = (s_reg.ir.modify_sel == X_IMM) ? imm[CHAR_W-1:0] : char_at(s_reg.word, s_reg.pos);
      rsel = s_reg.r[s_reg.ir.data_slot_sel];
      // unsigned magnitudes, carry or borrow in top bit
      sum9 = {1'b0, rsel} + {1'b0, opnd};
      dif9 = {1'b0, rsel} - {1'b0, opnd};
      // hold busy for counted memory cycles
      pace_end = PACE_W'(s_reg.cyc) * PACE_W'(MEM_CYCLE_CLKS);
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_next = s_reg;
      s_next.wb_ack = 1'b0;
      s_next.done = 1'b0;

      // Bus slave: one wait state, every address acknowledged
      if (wb_cyc_in && wb_stb_in && !s_reg.wb_ack) begin
         s_next.wb_ack = 1'b1;
         if (wb_adr_in == OFF_INSTR) begin
            s_next.wb_dat = s_reg.ir;
         end else if (wb_adr_in == OFF_STATUS) begin
            s_next.wb_dat = '0;
            s_next.wb_dat[ST_BUSY] = (s_reg.st != ST_IDLE);
            s_next.wb_dat[ST_OVF] = s_reg.ovf;
            s_next.wb_dat[ST_ILL] = s_reg.ill;
            s_next.wb_dat[ST_SKIP +: 2] = s_reg.skip;
            s_next.wb_dat[ST_CYC +: CYC_W] = s_reg.cyc;
         end else if (wb_adr_in == OFF_DATA_LOW) begin
            s_next.wb_dat = {s_reg.r[0], s_reg.r[1], s_reg.r[2], s_reg.r[3]};
         end else if (wb_adr_in == OFF_DATA_HIGH) begin
            s_next.wb_dat = {s_reg.r[4], s_reg.r[5], s_reg.r[6], s_reg.r[7]};
         end else begin
            s_next.wb_dat = '0;
         end
         if (wb_we_in) begin
            if (wb_adr_in == OFF_INSTR && s_reg.st == ST_IDLE) begin
               // instruction fields captured; fetch is first cycle
               s_next.ir = wb_dat_in;
               s_next.st = ST_ADDR;
               s_next.cyc = CYC_W'(1);
               s_next.pace = '0;
               s_next.skip = 2'h0;
               s_next.ill = 1'b0;
            end else if (wb_adr_in == OFF_STATUS && wb_dat_in[ST_OVF]) begin
               s_next.ovf = 1'b0;
            end else if (s_reg.st == ST_IDLE) begin
               // Registers are lane-reversed: byte lane 3 is A or E
               for (int b = 0; b < CPW; b++) begin
                  if (wb_sel_in[b] && wb_adr_in == OFF_DATA_LOW) begin
                     s_next.r[CPW-1-b] = wb_dat_in[b*CHAR_W +: CHAR_W];
                  end else if (wb_sel_in[b] && wb_adr_in == OFF_DATA_HIGH) begin
                     s_next.r[NUM_REGS-1-b] = wb_dat_in[b*CHAR_W +: CHAR_W];
                  end
               end
            end
         end
      end

      if (s_reg.st != ST_IDLE) begin
         s_next.pace = s_reg.pace + PACE_W'(1);
      end

      case (s_reg.st)
         ST_ADDR: begin
            if (!legal) begin
               s_next.ill = 1'b1;
               s_next.st = ST_PACE;
            end else if (s_reg.ir.modify_sel == X_IMM && imm_ok) begin
               s_next.st = ST_EXEC;
            end else if (s_reg.ir.deref_flag) begin
               // one memory cycle per indirect level
               s_next.cyc = s_reg.cyc + CYC_W'(1);
               s_next.mreq = 1'b1;
               s_next.mwe = 1'b0;
               s_next.maddr = ea[17:2];
               s_next.st = ST_IND;
            end else begin
               s_next.cyc = s_reg.cyc + CYC_W'(1);
               s_next.maddr = ea[17:2];
               s_next.pos = ea[1:0];
               s_next.word = '0;
               s_next.mreq = needs_rd;
               s_next.mwe = 1'b0;
               s_next.st = needs_rd ? ST_OPRD : ST_EXEC;
            end
         end
         ST_IND: begin
            if (mem_ack_in) begin
               s_next.mreq = 1'b0;
               s_next.ir.deref_flag = mem_rdata_in[21];
               s_next.ir.modify_sel = mem_rdata_in[20:18];
               s_next.ir.memory_loc = mem_rdata_in[17:2];
               s_next.ir.byte_pos = mem_rdata_in[1:0];
               s_next.st = ST_ADDR;
            end
         end
         ST_OPRD: begin
            if (mem_ack_in) begin
               s_next.mreq = 1'b0;
               s_next.word = mem_rdata_in;
               s_next.st = ST_EXEC;
            end
         end
         ST_EXEC: begin
            s_next.st = ST_PACE;
            case (s_reg.ir.op)
               OP_LOAD_CHAR: begin
                  s_next.r[s_reg.ir.data_slot_sel] = opnd;
               end
               OP_LOAD_CHAR_MASKED: begin
                  s_next.r[s_reg.ir.data_slot_sel] = (rsel & ~s_reg.r[REG_MASK]) |
                                                     (opnd & s_reg.r[REG_MASK]);
               end
               OP_STORE_CHAR: begin
                  s_next.mwdata = put_char(s_reg.word, s_reg.pos, rsel);
                  s_next.st = ST_OPWR;
               end
               OP_STORE_CHAR_MASKED: begin
                  // zeros in E keep memory bits
                  s_next.mwdata = put_char(s_reg.word, s_reg.pos,
                                           (opnd & ~s_reg.r[REG_MASK]) |
                                           (rsel & s_reg.r[REG_MASK]));
                  s_next.st = ST_OPWR;
               end
               OP_ADD_CHAR: begin
                  s_next.r[s_reg.ir.data_slot_sel] = sum9[CHAR_W-1:0];
                  if (sum9[CHAR_W]) begin
                     s_next.ovf = 1'b1;
                  end
               end
               OP_SUB_CHAR: begin
                  s_next.r[s_reg.ir.data_slot_sel] = dif9[CHAR_W-1:0];
                  if (dif9[CHAR_W]) begin
                     s_next.ovf = 1'b1;
                  end
               end
               OP_COMPARE_CHAR_MEM: begin
                  // three-way result, skip costs a cycle
                  if (rsel == opnd) begin
                     s_next.skip = 2'h1;
                     s_next.cyc = s_reg.cyc + CYC_W'(1);
                  end else if (rsel < opnd) begin
                     s_next.skip = 2'h2;
                     s_next.cyc = s_reg.cyc + CYC_W'(1);
                  end
               end
               default: begin
                  case (s_reg.ir.data_slot_sel)
                     GRP_LOAD_LOW: begin
                        // positions one to four into A-D
                        for (int k = 0; k < CPW; k++) begin
                           s_next.r[int'(REG_LOW_BASE) + k] = char_at(s_reg.word, 2'(k));
                        end
                     end
                     GRP_LOAD_HIGH: begin
                        // positions one to four into E-H
                        for (int k = 0; k < CPW; k++) begin
                           s_next.r[int'(REG_HIGH_BASE) + k] = char_at(s_reg.word, 2'(k));
                        end
                     end
                     GRP_STORE_LOW: begin
                        // A-D to positions one to four
                        s_next.mwdata = {s_reg.r[0], s_reg.r[1], s_reg.r[2], s_reg.r[3]};
                        s_next.st = ST_OPWR;
                     end
                     GRP_STORE_HIGH: begin
                        // E-H to positions one to four
                        s_next.mwdata = {s_reg.r[4], s_reg.r[5], s_reg.r[6], s_reg.r[7]};
                        s_next.st = ST_OPWR;
                     end
                     GRP_LOAD_INDEX_TWO, GRP_LOAD_INDEX_THREE: begin
                        // right 16 bits into pair, A or B high
                        if (s_reg.ir.modify_sel == X_IMM) begin
                           {s_next.r[s_reg.ir.data_slot_sel - 3'h4],
                            s_next.r[s_reg.ir.data_slot_sel - 3'h2]} = imm[PAIR_W-1:0];
                        end else begin
                           {s_next.r[s_reg.ir.data_slot_sel - 3'h4],
                            s_next.r[s_reg.ir.data_slot_sel - 3'h2]} = s_reg.word[PAIR_W-1:0];
                        end
                     end
                     default: begin
                        // pair into right half of word
                        s_next.mwdata = {s_reg.word[31:PAIR_W],
                                         s_reg.r[s_reg.ir.data_slot_sel - 3'h6],
                                         s_reg.r[s_reg.ir.data_slot_sel - 3'h4]};
                        s_next.st = ST_OPWR;
                     end
                  endcase
               end
            endcase
            if (s_next.st == ST_OPWR) begin
               s_next.mreq = 1'b1;
               s_next.mwe = 1'b1;
            end
         end
         ST_OPWR: begin
            if (mem_ack_in) begin
               s_next.mreq = 1'b0;
               s_next.mwe = 1'b0;
               s_next.st = ST_PACE;
            end
         end
         ST_PACE: begin
            if (s_reg.pace + PACE_W'(1) >= pace_end) begin
               s_next.st = ST_IDLE;
               s_next.done = 1'b1;
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_dat_out = s_reg.wb_dat;
   assign wb_ack_out = s_reg.wb_ack;
   assign mem_req_out = s_reg.mreq;
   assign mem_we_out = s_reg.mwe;
   assign mem_addr_out = s_reg.maddr;
   assign mem_wdata_out = s_reg.mwdata;
   assign busy_out = (s_reg.st != ST_IDLE);
   assign done_out = s_reg.done;
   assign skip_count_out = s_reg.skip;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n);

   bus_ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held two cycles");
   mem_hold_a: assert property (mem_req_out && !mem_ack_in |=>
      mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out))
      else $error("memory request dropped early");
   start_count_a: assert property (s_reg.st == ST_IDLE && s_next.st == ST_ADDR |=>
      s_reg.cyc == CYC_W'(1))
      else $error("fetch cycle not counted");
   indirect_cost_a: assert property (s_reg.st == ST_ADDR && s_next.st == ST_IND |=>
      s_reg.cyc == $past(s_reg.cyc) + CYC_W'(1) ##1 !$stable(s_reg.st) || mem_req_out)
      else $error("indirect level not counted");
   index_free_a: assert property (s_reg.st == ST_ADDR && s_next.st == ST_OPRD |=>
      s_reg.cyc == $past(s_reg.cyc) + CYC_W'(1))
      else $error("indexing changed cycle count");
   imm_no_mem_a: assert property (s_reg.st == ST_ADDR && s_next.st == ST_EXEC &&
      s_reg.ir.modify_sel == X_IMM && imm_ok |=> !mem_req_out ##1 !mem_req_out)
      else $error("immediate operand touched memory");
   mask_load_a: assert property (s_reg.st == ST_EXEC &&
      s_reg.ir.op == OP_LOAD_CHAR_MASKED |->
      ((s_next.r[s_reg.ir.data_slot_sel] ^ rsel) & ~s_reg.r[REG_MASK]) == '0)
      else $error("masked load changed unmasked bit");
   add_ovf_a: assert property (s_reg.st == ST_EXEC && s_reg.ir.op == OP_ADD_CHAR &&
      sum9[CHAR_W] |=> s_reg.ovf)
      else $error("carry did not set overflow");
   sub_ovf_a: assert property (s_reg.st == ST_EXEC && s_reg.ir.op == OP_SUB_CHAR &&
      dif9[CHAR_W] |=> s_reg.ovf)
      else $error("borrow did not set overflow");
   cmp_skip_a: assert property (s_reg.st == ST_EXEC &&
      s_reg.ir.op == OP_COMPARE_CHAR_MEM && rsel < opnd |=>
      s_reg.skip == 2'h2 && s_reg.cyc == $past(s_reg.cyc) + CYC_W'(1))
      else $error("less-than compare did not skip two");

   indirect_c: cover property (s_reg.st == ST_IND ##[1:20] s_reg.st == ST_IND);
   skip_two_c: cover property (done_out && skip_count_out == 2'h2);
   store_group_c: cover property (mem_we_out && mem_ack_in && s_reg.ir.op == OP_GROUP);
   ovf_c: cover property ($rose(s_reg.ovf));
endmodule
`default_nettype wire

// *** hdl/cie_pkg.sv ***
// Constants and types shared by the character instruction executor
package cie_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int MEM_CYCLE_NS = 2000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int MEM_CYCLE_CLKS = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PACE_W = 18;
   localparam int CYC_W = 8;

   // ****************************************
   // Word layout
   // ****************************************
   localparam int CHAR_W = 8;
   localparam int CPW = 4;
   localparam int NUM_REGS = 8;
   localparam int PAIR_W = 16;
   localparam logic [2:0] REG_MASK = 3'h4;
   localparam logic [2:0] REG_LOW_BASE = 3'h0;
   localparam logic [2:0] REG_HIGH_BASE = 3'h4;

   typedef struct packed {
      logic [5:0] op;
      logic modifier;
      logic [2:0] data_slot_sel;
      logic deref_flag;
      logic [2:0] modify_sel;
      logic [15:0] memory_loc;
      logic [1:0] byte_pos;
   } cie_instr_s;

   // ****************************************
   // Opcodes and decode values (arbitrary encoding)
   // ****************************************
   localparam logic [5:0] OP_LOAD_CHAR = 6'h01;
   localparam logic [5:0] OP_LOAD_CHAR_MASKED = 6'h02;
   localparam logic [5:0] OP_STORE_CHAR = 6'h03;
   localparam logic [5:0] OP_STORE_CHAR_MASKED = 6'h04;
   localparam logic [5:0] OP_GROUP = 6'h05;
   localparam logic [5:0] OP_ADD_CHAR = 6'h06;
   localparam logic [5:0] OP_SUB_CHAR = 6'h07;
   localparam logic [5:0] OP_COMPARE_CHAR_MEM = 6'h08;

   localparam logic [2:0] GRP_LOAD_LOW = 3'h0;
   localparam logic [2:0] GRP_LOAD_HIGH = 3'h1;
   localparam logic [2:0] GRP_STORE_LOW = 3'h2;
   localparam logic [2:0] GRP_STORE_HIGH = 3'h3;
   localparam logic [2:0] GRP_LOAD_INDEX_TWO = 3'h4;
   localparam logic [2:0] GRP_LOAD_INDEX_THREE = 3'h5;
   localparam logic [2:0] GRP_SAVE_INDEX_TWO = 3'h6;
   localparam logic [2:0] GRP_SAVE_INDEX_THREE = 3'h7;

   localparam logic [2:0] X_NONE = 3'h0;
   localparam logic [2:0] X_IMM = 3'h1;
   localparam logic [2:0] X_PAIR_TWO = 3'h2;
   localparam logic [2:0] X_PAIR_THREE = 3'h3;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [3:0] OFF_INSTR = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_DATA_LOW = 4'h8;
   localparam logic [3:0] OFF_DATA_HIGH = 4'hc;
   localparam int ST_BUSY = 0;
   localparam int ST_OVF = 1;
   localparam int ST_ILL = 2;
   localparam int ST_SKIP = 4;
   localparam int ST_CYC = 8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_IND = 3'b010,
      ST_OPRD = 3'b011,
      ST_EXEC = 3'b100,
      ST_OPWR = 3'b101,
      ST_PACE = 3'b110
   } cie_state_e;
endpackage

// *** verification/cie_mem_model.sv ***
// Behavioural core memory answering the executor's word requests
`timescale 1ns/10ps
`default_nettype none
module cie_mem_model (
   input wire logic clk_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [15:0] addr_in,
   input wire logic [31:0] wdata_in,
   output logic [31:0] rdata_out,
   output logic ack_out
);
   logic [31:0] mem [0:65535];
   int wait_cnt = 1;
   initial begin
      ack_out = 1'b0;
      rdata_out = 32'h0;
   end
   // Random wait so both prompt and slow answers occur
   always @(posedge clk_in) begin
      if (ack_out) begin
         ack_out <= 1'b0;
         // Released bus shows the inverse so stale data cannot pass
         rdata_out <= ~rdata_out;
      end else if (req_in && wait_cnt > 0) begin
         wait_cnt <= wait_cnt - 1;
      end else if (req_in) begin
         ack_out <= 1'b1;
         wait_cnt <= $urandom_range(5);
         if (we_in)
            mem[addr_in] <= wdata_in;
         else
            rdata_out <= mem[addr_in];
      end
   end
endmodule
`default_nettype wire

// *** verification/cie_char_exec_bench.sv ***
// Self-checking bench for the character instruction executor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module cie_char_exec_bench;
   import cie_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'hf;
   logic [31:0] dat = 32'h0, rdat, mrd, mwd, st;
   logic ack, mreq, mwe, mack, busy, done;
   logic [15:0] madr;
   logic [1:0] skip;
   logic [7:0] rg [8];
   int n_mismatch = 0;
   int checked = 0;
   always #2.5 clk = ~clk;
   cie_char_exec u_dut (.clk_in(clk), .rstn_in(rstn), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .mem_req_out(mreq), .mem_we_out(mwe), .mem_addr_out(madr),
      .mem_wdata_out(mwd), .mem_rdata_in(mrd), .mem_ack_in(mack), .busy_out(busy),
      .done_out(done), .skip_count_out(skip));
   cie_mem_model u_mem (.clk_in(clk), .req_in(mreq), .we_in(mwe), .addr_in(madr),
      .wdata_in(mwd), .rdata_out(mrd), .ack_out(mack));
   task automatic complete_run();
      if (n_mismatch == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Thirty-two instructions of at most four memory cycles each
   initial begin
      #400000;
      n_mismatch++;
      complete_run();
   end
   // ****************************************
   // Bus and instruction helpers
   // ****************************************
   function automatic logic [7:0] ch(input logic [31:0] w, input logic [1:0] p);
      return w[31 - 8 * p -: 8];
   endfunction
   function automatic logic [31:0] grp(input int b);
      return {rg[b], rg[b + 1], rg[b + 2], rg[b + 3]};
   endfunction
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      {cyc, stb, we} <= 3'h0;
   endtask
   task automatic set_regs();
      logic [31:0] q;
      wb(1'b1, OFF_DATA_LOW, grp(0), q);
      wb(1'b1, OFF_DATA_HIGH, grp(4), q);
   endtask
   task automatic chk_regs();
      logic [31:0] q;
      wb(1'b0, OFF_DATA_LOW, 32'h0, q);
      `CHK("data_low", q, grp(0))
      wb(1'b0, OFF_DATA_HIGH, 32'h0, q);
      `CHK("data_high", q, grp(4))
   endtask
   task automatic run(input logic [5:0] op, input logic [2:0] r, input logic i,
      input logic [2:0] x, input logic [17:0] a, input logic [7:0] cy, input logic [1:0] sk);
      int n = 0;
      wb(1'b1, OFF_INSTR, {op, 1'b0, r, i, x, a}, st);
      `CHK("busy", busy, 1'b1)
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'b1);
      `CHK("span", n, int'(cy) * MEM_CYCLE_CLKS)
      `CHK("busy_end", busy, 1'b0)
      wb(1'b0, OFF_STATUS, 32'h0, st);
      `CHK("cycles", st[15:8], cy)
      `CHK("skip", st[5:4], sk)
      `CHK("skip_out", skip, sk)
      `CHK("illegal", st[ST_ILL], !(op inside {[OP_LOAD_CHAR:OP_COMPARE_CHAR_MEM]}))
   endtask
   task automatic grun(input logic [2:0] s, input logic [2:0] x, input logic [17:0] a,
      input logic [7:0] cy);
      run(OP_GROUP, s, 1'b0, x, a, cy, 2'h0);
   endtask
   initial begin
      logic [31:0] q, wd;
      logic [17:0] a, ea;
      logic [7:0] b, m;
      logic [5:0] op;
      logic ov;
      int r;
      void'($urandom(9217));
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
         foreach (rg[j]) rg[j] = 8'($urandom);
         set_regs();
         r = $urandom_range(7);
         a = 18'($urandom_range(18'h0ffff));
         wd = $urandom;
         ea = a + (k < 2 ? 18'h0 : k < 4 ? 18'({rg[k - 2], rg[k]}) : 18'(rg[k]));
         u_mem.mem[ea[17:2]] = wd;
         run(OP_LOAD_CHAR, 3'(r), 1'b0, k < 2 ? X_NONE : 3'(k), a, 8'h2, 2'h0);
         rg[r] = ch(wd, ea[1:0]);
         chk_regs();
      end
      run(OP_LOAD_CHAR, 3'h6, 1'b0, X_IMM, a, 8'h1, 2'h0);
      rg[6] = a[7:0];
      chk_regs();
      // Pair high byte cleared so the pointer chain cannot overlap
      rg[0] = 8'h0;
      set_regs();
      wd = $urandom;
      ea = 18'h00400 + {rg[0], rg[2]};
      u_mem.mem[ea[17:2]] = {10'h0, 1'b1, 3'h5, 18'h00801};
      ea = 18'h00801 + rg[5];
      u_mem.mem[ea[17:2]] = {10'h0, 1'b0, X_NONE, 18'h00c02};
      u_mem.mem[16'h0300] = wd;
      run(OP_LOAD_CHAR, 3'h3, 1'b1, X_PAIR_TWO, 18'h00400, 8'h4, 2'h0);
      rg[3] = ch(wd, 2'h2);
      chk_regs();
      for (int k = 0; k < 2; k++) begin
         r = $urandom_range(7);
         a = {16'h0500, 2'($urandom)};
         wd = $urandom;
         u_mem.mem[16'h0500] = wd;
         m = k ? rg[4] : 8'hff;
         op = k ? OP_STORE_CHAR_MASKED : OP_STORE_CHAR;
         run(op, 3'(r), 1'b0, X_NONE, a, 8'h2, 2'h0);
         wd[31 - 8 * a[1:0] -: 8] = (ch(wd, a[1:0]) & ~m) | (rg[r] & m);
         `CHK("stored", u_mem.mem[16'h0500], wd)
      end
      u_mem.mem[16'h0501] = wd;
      run(OP_LOAD_CHAR_MASKED, 3'h2, 1'b0, X_NONE, 18'h01405, 8'h2, 2'h0);
      rg[2] = (rg[2] & ~rg[4]) | (ch(wd, 2'h1) & rg[4]);
      chk_regs();
      for (int k = 0; k < 2; k++) begin
         wd = $urandom;
         u_mem.mem[16'h0600] = wd;
         grun(k ? GRP_LOAD_HIGH : GRP_LOAD_LOW, X_NONE, 18'h01800, 8'h2);
         for (int j = 0; j < 4; j++) rg[4 * k + j] = ch(wd, 2'(j));
         chk_regs();
         grun(k ? GRP_STORE_HIGH : GRP_STORE_LOW, X_NONE, 18'h01804, 8'h2);
         `CHK("group", u_mem.mem[16'h0601], grp(4 * k))
         u_mem.mem[16'h0700] = ~wd;
         grun(k ? GRP_LOAD_INDEX_THREE : GRP_LOAD_INDEX_TWO, X_NONE, 18'h01c00, 8'h2);
         {rg[k], rg[k + 2]} = ~wd[15:0];
         chk_regs();
         // Pair changed first so a store that skips the write is seen
         rg[k] = ~rg[k];
         set_regs();
         grun(k ? GRP_SAVE_INDEX_THREE : GRP_SAVE_INDEX_TWO, X_NONE, 18'h01c00, 8'h2);
         wd = ~wd;
         wd[15:8] = rg[k];
         `CHK("pair", u_mem.mem[16'h0700], wd)
      end
      grun(GRP_LOAD_INDEX_TWO, X_IMM, 18'h2bcd7, 8'h1);
      {rg[0], rg[2]} = 16'hbcd7;
      chk_regs();
      for (int k = 0; k < 6; k++) begin
         rg[k] = k == 0 ? 8'hff : k == 1 ? 8'h00 : 8'($urandom);
         b = k < 2 ? 8'h01 : 8'($urandom);
         set_regs();
         u_mem.mem[16'h0800] = {4{b}};
         op = k[0] ? OP_SUB_CHAR : OP_ADD_CHAR;
         run(op, 3'(k), 1'b0, X_NONE, 18'h02001, 8'h2, 2'h0);
         ov = k[0] ? rg[k] < b : {1'b0, rg[k]} + b > 9'h0ff;
         rg[k] = k[0] ? rg[k] - b : rg[k] + b;
         `CHK("overflow", st[ST_OVF], ov)
         chk_regs();
         wb(1'b1, OFF_STATUS, 32'h2, q);
      end
      for (int k = 0; k < 3; k++) begin
         u_mem.mem[16'h0900] = {4{8'h3f + 8'(k)}};
         rg[5] = 8'h40;
         set_regs();
         run(OP_COMPARE_CHAR_MEM, 3'h5, 1'b0, X_NONE, 18'h02403, 8'(k ? 3 : 2), 2'(k));
      end
      run(6'h3f, 3'h0, 1'b0, X_NONE, 18'h0, 8'h1, 2'h0);
      wb(1'b0, 4'h2, 32'h0, q);
      `CHK("unmapped", q, 32'h0)
      complete_run();
   end
endmodule
`default_nettype wire
